// ---- clk_rst_if.sv ----
// Carrier between the core clock/reset end and the reset controller end.
// Assumes both ends run on the same clk; reset_async is treated as a pin.
interface clk_rst_if;

	// Reset controller to core.
	logic        reset_async;
	logic        reset_status;
	logic        reconfig_reset;
	// Core to reset controller and client.
	logic        rx_pcs_ready;
	logic        rxmac_run;
	logic        rx_recover_run;
	logic        txmac_run;

	modport core (
		input  reset_async,
		input  reset_status,
		input  reconfig_reset,
		output rx_pcs_ready,
		output rxmac_run,
		output rx_recover_run,
		output txmac_run
	);

	modport ctrl (
		output reset_async,
		output reset_status,
		output reconfig_reset,
		input  rx_pcs_ready,
		input  rxmac_run,
		input  rx_recover_run,
		input  txmac_run
	);

endinterface

// ---- clk_rst_pkg.sv ----
// Shared constants for the core clock and reset block and its partner.
// Assumes one 100 MHz system clock; link clocks are modelled as run levels.
package clk_rst_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock rates in hertz, as reported on the rate outputs.
	localparam logic [31:0] TXMAC_HZ_40G  = 32'h129f_f6c8;
	localparam logic [31:0] TXMAC_HZ_100G = 32'h1748_3fd0;
	localparam logic [31:0] RXMAC_HZ_40G  = 32'h129f_f6c8;
	localparam logic [31:0] RXMAC_HZ_100G = 32'h1748_3fd0;
	localparam logic [31:0] RXREC_HZ_40G  = 32'h0f5d_ee50;
	localparam logic [31:0] RXREC_HZ_100G = 32'h1335_6839;

	////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int CLK_PERIOD_NS      = 10;
	localparam int RESET_HOLD_CYCLES  = 10;
	localparam int REF_SETTLE_CYCLES  = 10;
	localparam int SYNC_STAGES        = 3;
	localparam int TXPLL_LOCK_NS      = 200;
	localparam int TXPLL_LOCK_CYCLES  = TXPLL_LOCK_NS / CLK_PERIOD_NS;
	localparam int CDR_LOCK_NS        = 160;
	localparam int CDR_LOCK_CYCLES    = CDR_LOCK_NS / CLK_PERIOD_NS;
	localparam int PCS_ALIGN_NS       = 80;
	localparam int PCS_ALIGN_CYCLES   = PCS_ALIGN_NS / CLK_PERIOD_NS;
	localparam int FILTER_NS          = 320;
	localparam int FILTER_CYCLES      = FILTER_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Reset domains inside the core.
	localparam int DOM_TX       = 0;
	localparam int DOM_RX       = 1;
	localparam int DOM_STATUS   = 2;
	localparam int DOM_RECONFIG = 3;
	localparam int NUM_DOMAINS  = 4;

	////////////////////////////////////////////////////////////////////////
	// Interface widths.
	localparam int WORD_BITS = 64;

	function automatic int client_words(input bit speed_100g);
		return speed_100g ? 8 : 4;
	endfunction

	function automatic int custom_words(input bit speed_100g);
		return speed_100g ? 4 : 2;
	endfunction

	function automatic int lane_count(input bit speed_100g, input bit ten_lane);
		return (speed_100g && ten_lane) ? 10 : 4;
	endfunction

	function automatic int queue_count(input bit pfc_enable, input int pfc_queues);
		return pfc_enable ? pfc_queues : 1;
	endfunction

endpackage

// ---- clk_rst_sva.sv ----
// Checker on the link between the core end and the reset controller.
// Assumes it is instantiated beside the link, on the shared clock.
module clk_rst_sva #(
	parameter bit EXPORT = 1'b1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Controller to core.
	input wire logic reset_async,
	input wire logic reset_status,
	input wire logic reconfig_reset,
	// Core to controller.
	input wire logic rx_pcs_ready,
	input wire logic rxmac_run,
	input wire logic rx_recover_run,
	input wire logic txmac_run
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////
	// Counts how long the core reset has stood high.
	logic [7:0] high_cnt;

	always_ff @(posedge clk) begin
		if (srst || !reset_async)
			high_cnt <= 8'h00;
		else if (high_cnt != 8'hff)
			high_cnt <= high_cnt + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	a_hold_ten: assert property (
		$fell(reset_async) |->
			high_cnt >= 8'(clk_rst_pkg::RESET_HOLD_CYCLES))
		else $error("core reset released too early");

	a_ready_needs_rx: assert property (
		rx_pcs_ready |-> rxmac_run)
		else $error("ready without receive clock");

	a_export_tracks: assert property (
		rx_recover_run == (EXPORT && rxmac_run))
		else $error("recovered clock export wrong");

	a_reset_clears: assert property (
		reset_async [*4] |-> !(txmac_run || rxmac_run || rx_pcs_ready))
		else $error("clocks still running in core reset");

	a_tx_lock_time: assert property (
		$fell(reset_async) |-> !txmac_run [*8] ##[10:40] txmac_run)
		else $error("transmit clock start time wrong");

	a_rx_ready_delay: assert property (
		$rose(rxmac_run) |-> !rx_pcs_ready [*6] ##[1:4] rx_pcs_ready)
		else $error("receive ready delay wrong");

	a_loss_drops: assert property (
		$fell(rxmac_run) |-> !rx_pcs_ready && !rx_recover_run)
		else $error("receive loss not followed");

	a_tx_stays: assert property (
		txmac_run && !reset_async |=> txmac_run)
		else $error("transmit clock stopped without reset");

endmodule // clk_rst_sva

// ---- core_clk_rst.sv ----
// Core end: MAC clock generation, recovered clock export and reset fan-out.
// Assumes clk at 100 MHz; serial data presence and the external TX MAC
// clock are pins and are synchronised here.
// Operation
// - TX MAC clock at 312.5 or 390.625 MHz.
// - External PLL option sources TX MAC clock.
// - RX MAC clock at 312.5 or 390.625 MHz.
// - Client trusts RX clock only when ready.
// - RX MAC clock comes from recovered data.
// - Recovered clock export only when option enabled.
// - Recovered clock 257.81 or 322.265625 MHz.
// - Recovered clock unfiltered; partner filters it.
// - One async reset resets whole core.
// - Partner holds core reset ten cycles.
// - Partner releases reset after reference stable.
// - Status reset clears control/status interface.
// - Reconfig reset only with reconfiguration port.
// - Client path 4 or 8 words.
// - Custom client path 2 or 4 words.
// - Serial links 4 or 10.
// - Queue count 1 or configured value.
module core_clk_rst #(
	parameter bit SPEED_100G                    = 1'b0,
	parameter bit TEN_LANE                      = 1'b1,
	parameter bit EXT_TXMAC_PLL                 = 1'b0,
	parameter bit recovered_clock_export_option = 1'b0,
	parameter bit HAS_RECONFIG                  = 1'b1,
	parameter bit PFC_ENABLE                    = 1'b0,
	parameter int PFC_QUEUES                    = 8
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        srst,
	// Link to the reset controller.
	clk_rst_if.core          link,
	// Pins.
	input  wire logic        rx_serial_present,
	input  wire logic        clk_txmac_in_alive,
	// Clock status.
	output logic [31:0]      txmac_freq_hz,
	output logic             txmac_from_ext,
	output logic [31:0]      rxmac_freq_hz,
	output logic [31:0]      rx_recover_freq_hz,
	// Domain resets.
	output logic             tx_rst,
	output logic             rx_rst,
	output logic             status_if_rst,
	output logic             reconfig_if_rst,
	output logic             reset_too_short,
	// Interface widths.
	output logic [7:0]       client_word_count,
	output logic [7:0]       custom_word_count,
	output logic [7:0]       serial_lane_count,
	output logic [7:0]       fc_queue_count
);

	////////////////////////////////////////////////////////////////////////
	// Derived widths.

	localparam int CLIENT_N = clk_rst_pkg::client_words(SPEED_100G);
	localparam int CUSTOM_W = clk_rst_pkg::custom_words(SPEED_100G);
	localparam int LANES    = clk_rst_pkg::lane_count(SPEED_100G, TEN_LANE);
	localparam int QUEUES   =
		clk_rst_pkg::queue_count(PFC_ENABLE, PFC_QUEUES);
	localparam int SS       = clk_rst_pkg::SYNC_STAGES;

	always_ff @(posedge clk) begin
		client_word_count <= 8'(CLIENT_N);
		custom_word_count <= 8'(CUSTOM_W);
		serial_lane_count <= 8'(LANES);
		fc_queue_count    <= 8'(QUEUES);
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic rst_meta;
	logic rst_sync;
	logic present_meta;
	logic present_sync;
	logic ext_meta;
	logic ext_sync;

	always_ff @(posedge clk) begin
		rst_meta     <= link.reset_async;
		rst_sync     <= rst_meta;
		present_meta <= rx_serial_present;
		present_sync <= present_meta;
		ext_meta     <= clk_txmac_in_alive;
		ext_sync     <= ext_meta;
	end

	logic core_rst;
	assign core_rst = srst | rst_sync;

	////////////////////////////////////////////////////////////////////////
	// Reset hold check.

	logic [7:0] hold_cnt;
	logic       rst_sync_d;

	always_ff @(posedge clk) begin
		if (srst) begin
			hold_cnt <= 8'h00;
		end else if (!rst_sync) begin
			hold_cnt <= 8'h00;
		end else if (hold_cnt != 8'hff) begin
			hold_cnt <= hold_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rst_sync_d <= 1'b0;
		end else begin
			rst_sync_d <= rst_sync;
		end
	end

	// flag a reset released too early.
	always_ff @(posedge clk) begin
		if (srst) begin
			reset_too_short <= 1'b0;
		end else if (rst_sync_d && !rst_sync) begin
			reset_too_short <=
				hold_cnt < 8'(clk_rst_pkg::RESET_HOLD_CYCLES);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-domain reset synchronisers.

	logic [clk_rst_pkg::NUM_DOMAINS-1:0] dom_req;
	logic [clk_rst_pkg::NUM_DOMAINS-1:0] dom_rst;

	always_comb begin
		dom_req = '0;
		dom_req[clk_rst_pkg::DOM_TX] = core_rst;
		dom_req[clk_rst_pkg::DOM_RX] = core_rst;
		dom_req[clk_rst_pkg::DOM_STATUS] = core_rst | link.reset_status;
		// reconfig reset only when the port exists.
		dom_req[clk_rst_pkg::DOM_RECONFIG] =
			HAS_RECONFIG & (core_rst | link.reconfig_reset);
	end

	genvar d;
	generate
		for (d = 0; d < clk_rst_pkg::NUM_DOMAINS; d++) begin : g_dom
			logic [SS-1:0] chain;
			// assert at once, release after the chain drains.
			always_ff @(posedge clk) begin
				if (dom_req[d]) begin
					chain <= '1;
				end else begin
					chain <= {chain[SS-2:0], 1'b0};
				end
			end
			assign dom_rst[d] = dom_req[d] | chain[SS-1];
		end
	endgenerate

	assign tx_rst          = dom_rst[clk_rst_pkg::DOM_TX];
	assign rx_rst          = dom_rst[clk_rst_pkg::DOM_RX];
	assign status_if_rst   = dom_rst[clk_rst_pkg::DOM_STATUS];
	assign reconfig_if_rst = dom_rst[clk_rst_pkg::DOM_RECONFIG];

	////////////////////////////////////////////////////////////////////////
	// TX MAC clock.

	logic [15:0] txpll_cnt;
	logic        txpll_locked;

	always_ff @(posedge clk) begin
		if (tx_rst) begin
			txpll_cnt    <= 16'h0000;
			txpll_locked <= 1'b0;
		end else if (txpll_cnt ==
			16'(clk_rst_pkg::TXPLL_LOCK_CYCLES - 1)) begin
			txpll_locked <= 1'b1;
		end else begin
			txpll_cnt <= txpll_cnt + 16'h0001;
		end
	end

	// external PLL drives the TX MAC clock.
	always_ff @(posedge clk) begin
		if (tx_rst) begin
			link.txmac_run <= 1'b0;
			txmac_from_ext <= 1'b0;
		end else begin
			link.txmac_run <= EXT_TXMAC_PLL ? ext_sync : txpll_locked;
			txmac_from_ext <= EXT_TXMAC_PLL;
		end
	end

	always_ff @(posedge clk) begin
		if (tx_rst) begin
			txmac_freq_hz <= 32'h0000_0000;
		end else begin
			txmac_freq_hz <= SPEED_100G ? clk_rst_pkg::TXMAC_HZ_100G
				: clk_rst_pkg::TXMAC_HZ_40G;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Recovered clock and RX MAC clock.

	logic [15:0] cdr_cnt;
	logic        cdr_locked;
	logic [15:0] align_cnt;

	always_ff @(posedge clk) begin
		if (rx_rst || !present_sync) begin
			cdr_cnt    <= 16'h0000;
			cdr_locked <= 1'b0;
		end else if (cdr_cnt ==
			16'(clk_rst_pkg::CDR_LOCK_CYCLES - 1)) begin
			cdr_locked <= 1'b1;
		end else begin
			cdr_cnt <= cdr_cnt + 16'h0001;
		end
	end

	// ready only once the recovered clock settles.
	always_ff @(posedge clk) begin
		if (rx_rst || !cdr_locked) begin
			align_cnt         <= 16'h0000;
			link.rx_pcs_ready <= 1'b0;
		end else if (align_cnt ==
			16'(clk_rst_pkg::PCS_ALIGN_CYCLES - 1)) begin
			link.rx_pcs_ready <= 1'b1;
		end else begin
			align_cnt <= align_cnt + 16'h0001;
		end
	end

	// RX MAC clock follows the recovered clock.
	always_ff @(posedge clk) begin
		if (rx_rst) begin
			link.rxmac_run <= 1'b0;
			rxmac_freq_hz  <= 32'h0000_0000;
		end else begin
			link.rxmac_run <= cdr_locked;
			rxmac_freq_hz  <= SPEED_100G ? clk_rst_pkg::RXMAC_HZ_100G
				: clk_rst_pkg::RXMAC_HZ_40G;
		end
	end

	always_ff @(posedge clk) begin
		if (rx_rst || !recovered_clock_export_option) begin
			link.rx_recover_run <= 1'b0;
			rx_recover_freq_hz  <= 32'h0000_0000;
		end else begin
			link.rx_recover_run <= cdr_locked;
			rx_recover_freq_hz  <= SPEED_100G ?
				clk_rst_pkg::RXREC_HZ_100G : clk_rst_pkg::RXREC_HZ_40G;
		end
	end

endmodule // core_clk_rst

// ---- ethernet_core_clock_reset_bench.sv ----
// Bench: core end and controller end joined by one link, plus a second
// core end (100G, external PLL) whose link the bench drives itself.
// Assumes the package, interface and both design modules come first.
module ethernet_core_clock_reset_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] ONE  = 32'h1;
	localparam logic [31:0] ZERO = 32'h0;

	// Configurations of the controller and the two core ends.
	localparam bit CFG_FPLL       = 1'b1;
	localparam bit CFG_EXPORT     = 1'b1;
	localparam bit CFG_100G       = 1'b1;
	localparam bit CFG_EXT_PLL    = 1'b1;
	localparam bit CFG_RECONFIG_B = 1'b0;
	localparam bit CFG_PFC        = 1'b1;
	localparam int CFG_QUEUES     = 5;

	logic        clk      = 1'b0;
	logic        srst     = 1'b1;
	logic        ref_ok   = 1'b0;
	logic        fpll_lk  = 1'b1;
	logic        core_req = 1'b0;
	logic        stat_req = 1'b0;
	logic        rcfg_req = 1'b0;
	logic        present  = 1'b0;
	logic        ext_b    = 1'b0;
	logic        trusted, filtered, running;
	logic [31:0] tx_hz, rx_hz, rec_hz, tx_hz_b, rec_hz_b;
	logic        from_ext, tx_rst, rx_rst, st_rst, rc_rst, short;
	logic        from_ext_b, rc_rst_b, short_b;
	logic [7:0]  cw, sw, ln, qc, cw_b, sw_b, ln_b, qc_b;
	int          miscompares  = 0;
	int          total_checks = 0;

	clk_rst_if link_a ();
	clk_rst_if link_b ();

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	reset_ctrl #(.USE_FPLL(CFG_FPLL)) u_reset_ctrl (
		.clk(clk), .srst(srst), .link(link_a.ctrl),
		.ref_clk_stable(ref_ok), .fpll_locked(fpll_lk),
		.core_reset_req(core_req), .status_reset_req(stat_req),
		.reconfig_reset_req(rcfg_req), .rx_domain_trusted(trusted),
		.tx_ref_filtered(filtered), .core_running(running));

	core_clk_rst #(.recovered_clock_export_option(CFG_EXPORT))
	u_core_clk_rst (
		.clk(clk), .srst(srst), .link(link_a.core),
		.rx_serial_present(present), .clk_txmac_in_alive(ext_b),
		.txmac_freq_hz(tx_hz), .txmac_from_ext(from_ext),
		.rxmac_freq_hz(rx_hz), .rx_recover_freq_hz(rec_hz),
		.tx_rst(tx_rst), .rx_rst(rx_rst), .status_if_rst(st_rst),
		.reconfig_if_rst(rc_rst), .reset_too_short(short),
		.client_word_count(cw), .custom_word_count(sw),
		.serial_lane_count(ln), .fc_queue_count(qc));

	core_clk_rst #(.SPEED_100G(CFG_100G), .EXT_TXMAC_PLL(CFG_EXT_PLL),
		.HAS_RECONFIG(CFG_RECONFIG_B), .PFC_ENABLE(CFG_PFC),
		.PFC_QUEUES(CFG_QUEUES))
	u_core_clk_rst_b (
		.clk(clk), .srst(srst), .link(link_b.core),
		.rx_serial_present(present), .clk_txmac_in_alive(ext_b),
		.txmac_freq_hz(tx_hz_b), .txmac_from_ext(from_ext_b),
		.rxmac_freq_hz(), .rx_recover_freq_hz(rec_hz_b),
		.tx_rst(), .rx_rst(), .status_if_rst(),
		.reconfig_if_rst(rc_rst_b), .reset_too_short(short_b),
		.client_word_count(cw_b), .custom_word_count(sw_b),
		.serial_lane_count(ln_b), .fc_queue_count(qc_b));

	clk_rst_sva #(.EXPORT(CFG_EXPORT)) u_clk_rst_sva (
		.clk(clk), .srst(srst), .reset_async(link_a.reset_async),
		.reset_status(link_a.reset_status),
		.reconfig_reset(link_a.reconfig_reset),
		.rx_pcs_ready(link_a.rx_pcs_ready), .rxmac_run(link_a.rxmac_run),
		.rx_recover_run(link_a.rx_recover_run),
		.txmac_run(link_a.txmac_run));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_running();
		for (int i = 0; i < 60 && running !== 1'b1; i++)
			step(1);
		check("core_running", running, ONE);
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		final_report();
	end

	initial begin
		link_b.reset_async = 1'b1;
		link_b.reset_status = 1'b0;
		link_b.reconfig_reset = 1'b0;
		step(5);
		check("tx_rst", tx_rst, ONE);
		check("tx_hz", tx_hz, ZERO);
		check("client", cw, 32'h4);
		check("custom", sw, 32'h2);
		check("lanes", ln, 32'h4);
		check("queues", qc, ONE);
		check("client_b", cw_b, 32'h8);
		check("custom_b", sw_b, 32'h4);
		check("lanes_b", ln_b, 32'ha);
		check("queues_b", qc_b, 32'h5);
		step(15);
		srst = 1'b0;
		step(10);
		check("held", link_a.reset_async, ONE);
		ref_ok = 1'b1;
		wait_running();
		step(35);
		check("tx_run", link_a.txmac_run, ONE);
		check("tx_hz", tx_hz, clk_rst_pkg::TXMAC_HZ_40G);
		check("from_ext", from_ext, ZERO);
		check("tx_rst", tx_rst, ZERO);
		check("st_rst", st_rst, ZERO);
		check("rc_rst", rc_rst, ZERO);
		check("short", short, ZERO);
		check("rx_run", link_a.rxmac_run, ZERO);
		check("trusted", trusted, ZERO);
		end_test("bring_up");

		present = 1'b1;
		step(32);
		check("rx_run", link_a.rxmac_run, ONE);
		check("ready", link_a.rx_pcs_ready, ONE);
		check("rec_run", link_a.rx_recover_run, ONE);
		check("rx_hz", rx_hz, clk_rst_pkg::RXMAC_HZ_40G);
		check("rec_hz", rec_hz, clk_rst_pkg::RXREC_HZ_40G);
		check("trusted", trusted, ONE);
		step(35);
		check("filtered", filtered, ONE);
		present = 1'b0;
		step(4);
		check("ready", link_a.rx_pcs_ready, ZERO);
		check("rec_run", link_a.rx_recover_run, ZERO);
		step(1);
		check("trusted", trusted, ZERO);
		end_test("receive");

		for (int k = 0; k < 2; k++) begin
			stat_req = (k == 0);
			rcfg_req = (k == 1);
			step(1);
			check("if_rst", k ? rc_rst : st_rst, ONE);
			check("tx_rst", tx_rst, ZERO);
			stat_req = 1'b0;
			rcfg_req = 1'b0;
			step(6);
			check("if_rst", k ? rc_rst : st_rst, ZERO);
		end
		end_test("port_resets");

		core_req = 1'b1;
		fpll_lk = 1'b0;
		step(1);
		core_req = 1'b0;
		step(5);
		check("tx_rst", tx_rst, ONE);
		check("rx_rst", rx_rst, ONE);
		check("st_rst", st_rst, ONE);
		check("rc_rst", rc_rst, ONE);
		step(20);
		check("held", link_a.reset_async, ONE);
		fpll_lk = 1'b1;
		wait_running();
		step(35);
		check("tx_run", link_a.txmac_run, ONE);
		check("short", short, ZERO);
		end_test("core_reset");

		ext_b = 1'b1;
		present = 1'b1;
		link_b.reset_async = 1'b0;
		step(10);
		check("tx_run_b", link_b.txmac_run, ONE);
		check("from_ext_b", from_ext_b, ONE);
		check("tx_hz_b", tx_hz_b, clk_rst_pkg::TXMAC_HZ_100G);
		check("rec_hz_b", rec_hz_b, ZERO);
		link_b.reconfig_reset = 1'b1;
		step(2);
		check("rc_rst_b", rc_rst_b, ZERO);
		link_b.reconfig_reset = 1'b0;
		ext_b = 1'b0;
		step(4);
		check("tx_run_b", link_b.txmac_run, ZERO);
		check("tx_run", link_a.txmac_run, ONE);
		step(8);
		check("rx_run_b", link_b.rxmac_run, ONE);
		check("rec_run_b", link_b.rx_recover_run, ZERO);
		for (int w = 4; w <= 12; w += 8) begin
			link_b.reset_async = 1'b1;
			step(w);
			link_b.reset_async = 1'b0;
			step(8);
			check("short_b", short_b, (w == 4) ? ONE : ZERO);
		end
		end_test("external_pll");
		final_report();
	end

endmodule // ethernet_core_clock_reset_bench

// ---- reset_ctrl.sv ----
// Partner end: system reset controller and client-side clock qualifiers.
// Assumes clk at 100 MHz; reference-stable and PLL-lock levels are pins.
module reset_ctrl #(
	parameter bit HAS_RECONFIG = 1'b1,
	parameter bit USE_FPLL     = 1'b0
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic srst,
	// Link to the core.
	clk_rst_if.ctrl   link,
	// Pins.
	input  wire logic ref_clk_stable,
	input  wire logic fpll_locked,
	// User requests.
	input  wire logic core_reset_req,
	input  wire logic status_reset_req,
	input  wire logic reconfig_reset_req,
	// User status.
	output logic      rx_domain_trusted,
	output logic      tx_ref_filtered,
	output logic      core_running
);

	typedef enum logic [1:0] {
		ST_WAIT_REF = 2'b00,
		ST_HOLD     = 2'b01,
		ST_RUN      = 2'b10
	} state_t;

	state_t     state;
	logic [7:0] hold_cnt;
	logic       ref_meta;
	logic       ref_sync;
	logic       lock_meta;
	logic       lock_sync;
	logic       ref_ok;

	always_ff @(posedge clk) begin
		ref_meta  <= ref_clk_stable;
		ref_sync  <= ref_meta;
		lock_meta <= fpll_locked;
		lock_sync <= lock_meta;
	end

	// reference stable, and locked when from a fractional PLL.
	assign ref_ok = ref_sync & (!USE_FPLL | lock_sync);

	////////////////////////////////////////////////////////////////////////
	// Core reset sequencing.

	always_ff @(posedge clk) begin
		if (srst || core_reset_req) begin
			state    <= ST_WAIT_REF;
			hold_cnt <= 8'h00;
		end else begin
			unique case (state)
				ST_WAIT_REF: begin
					hold_cnt <= 8'h00;
					if (ref_ok) begin
						state <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (!ref_ok) begin
						state    <= ST_WAIT_REF;
						hold_cnt <= 8'h00;
					end else if (hold_cnt ==
						8'(clk_rst_pkg::REF_SETTLE_CYCLES - 1)) begin
						state <= ST_RUN;
					end else begin
						hold_cnt <= hold_cnt + 8'h01;
					end
				end
				ST_RUN: begin
					hold_cnt <= 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			link.reset_async <= 1'b1;
		end else begin
			link.reset_async <= state != ST_RUN;
		end
	end

	assign core_running = state == ST_RUN;

	////////////////////////////////////////////////////////////////////////
	// Interface resets.

	// reconfig reset only when the port exists.
	always_ff @(posedge clk) begin
		if (srst) begin
			link.reset_status   <= 1'b1;
			link.reconfig_reset <= HAS_RECONFIG;
		end else begin
			link.reset_status   <= status_reset_req;
			link.reconfig_reset <= HAS_RECONFIG & reconfig_reset_req;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Client qualifiers.

	// trust the RX domain only while ready.
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_domain_trusted <= 1'b0;
		end else begin
			rx_domain_trusted <= link.rx_pcs_ready & link.rxmac_run;
		end
	end

	// filter the exported clock before using it as reference.
	logic [15:0] filt_cnt;

	always_ff @(posedge clk) begin
		if (srst || !link.rx_recover_run) begin
			filt_cnt        <= 16'h0000;
			tx_ref_filtered <= 1'b0;
		end else if (filt_cnt ==
			16'(clk_rst_pkg::FILTER_CYCLES - 1)) begin
			tx_ref_filtered <= 1'b1;
		end else begin
			filt_cnt <= filt_cnt + 16'h0001;
		end
	end

endmodule // reset_ctrl
